// ### i2c_interrupt_sources_bench.sv
// Self-checking testbench for the I2C interrupt source block
`default_nettype none
module i2c_interrupt_sources_bench;
   timeunit 1ns;
   timeprecision 1ps;
   import i2cis_pkg::*;

   // Stimulus, all driven at the falling edge
   logic core_clk = 1'h0, rst_n = 1'h0, sda_drive = 1'h1;
   logic master_active = 1'h0, slave_active = 1'h0, ack_strobe = 1'h0;
   logic master_stop_done = 1'h0, byte_active = 1'h0, addr_match = 1'h0, addr_rw = 1'h0;
   logic tx_fw_wr = 1'h0, tx_hw_rd = 1'h0, rx_hw_wr = 1'h0, rx_fw_rd = 1'h0;
   logic ext_addr_match_enable = 1'h0, ext_operation_enable = 1'h0;
   logic ext_clocked_addr_match_sel = 1'h0, ext_clocked_operation_sel = 1'h0;
   logic slave_busy_address_reject = 1'h0, addr_accept = 1'h1;
   logic buffer_memory_mode = 1'h0, command_response_mode = 1'h0;
   logic [7:0] addr_byte = 8'h00, tx_fw_data = 8'h00, rx_hw_data = 8'h00;
   i2cis_grp_t clr_src = '0, mask_src = '0;
   // Observed
   logic       scl, sda, slave_abort_q;
   logic [4:0] irq_q, interrupt_cause_reg;
   logic [7:0] tx_hw_data_q, rx_fw_data_q;
   i2cis_grp_t src_q;
   int compares = 0, miscompares = 0, aborts = 0;
   // Expected ec sources and engine writes for the four ec passes
   logic [7:0] ec_exp [4] = '{8'h07, 8'h03, 8'h0b, 8'h07};
   int         ec_wr [4]  = '{2, 1, 0, 1};
   logic       abort_seen = 1'h0;

   // Small FIFO depth keeps the full and empty cases short
   i2cis_core #(.DEPTH(4)) i2cis_core_inst (.core_clk, .rst_n, .scl_in(scl), .sda_in(sda),
      .sda_drive, .master_active, .slave_active, .ack_strobe, .master_stop_done,
      .byte_active, .addr_match, .addr_rw, .addr_byte, .tx_fw_wr, .tx_fw_data, .tx_hw_rd,
      .rx_hw_wr, .rx_hw_data, .rx_fw_rd, .tx_trig_level(3'h2), .rx_trig_level(3'h2),
      .ext_addr_match_enable, .ext_operation_enable, .ext_clocked_addr_match_sel,
      .ext_clocked_operation_sel, .slave_busy_address_reject, .addr_accept,
      .buffer_memory_mode, .command_response_mode, .clr_src, .mask_src, .src_q, .irq_q,
      .interrupt_cause_reg, .tx_hw_data_q, .rx_fw_data_q, .slave_abort_q);
   i2cis_bus_peer i2cis_bus_peer_inst (.core_clk, .scl, .sda);

   // 100 MHz clock
   always #5 core_clk = ~core_clk;
   // Abort stays up while the loss lasts, so rises are counted, away from the launching edge
   always @(negedge core_clk)
   begin
      if (slave_abort_q === 1'h1 && abort_seen !== 1'h1) aborts++;
      abort_seen = slave_abort_q;
   end

   task automatic chk(input string nm, input logic [7:0] e, input logic [7:0] g);
      compares++;
      if (g !== e)
      begin
         miscompares++;
         $display("BAD %s expected %h seen %h", nm, e, g);
      end
   endtask
   task automatic cyc(input int n);
      repeat (n) @(negedge core_clk);
   endtask
   task automatic clr(input int g, input logic [7:0] b);
      clr_src[g] = b;
      cyc(1);
      clr_src = '0;
   endtask
   task automatic am(input logic rw);
      addr_rw = rw;
      addr_match = 1'h1;
      cyc(1);
      addr_match = 1'h0;
   endtask
   task automatic report_and_stop();
      $display("Comparisons %0d, mismatches %0d", compares, miscompares);
      if (miscompares == 0 && compares > 0)
         $display("No errors found");
      else
         $display("Errors were found");
      $finish;
   endtask

   // Watchdog, far beyond the roughly 340 cycles the sequence needs
   initial
   begin
      repeat (20000) @(posedge core_clk);
      miscompares++;
      report_and_stop();
   end

   initial
   begin
      cyc(2);
      rst_n = 1'h1;
      cyc(2);
      chk("tx_src", 8'h07, src_q[2]);
      clr(2, 8'h04);
      chk("tx_src", 8'h07, src_q[2]);
      chk("irq", 8'h00, 8'(irq_q));
      mask_src = '1;
      cyc(2);
      chk("irq", 8'h04, 8'(irq_q));
      chk("cause", 8'h04, 8'(interrupt_cause_reg));
      // Master: peer pulls SDA low while the master releases it, then ACK and NACK
      master_active = 1'h1;
      i2cis_bus_peer_inst.bit_cell(1'h0);
      ack_strobe = 1'h1;
      cyc(1);
      ack_strobe = 1'h0;
      chk("m_src", 8'h05, src_q[0]);
      i2cis_bus_peer_inst.idle();
      ack_strobe = 1'h1;
      cyc(1);
      ack_strobe = 1'h0;
      master_stop_done = 1'h1;
      cyc(1);
      master_stop_done = 1'h0;
      cyc(3);
      chk("m_src", 8'h0f, src_q[0]);
      chk("irq", 8'h05, 8'(irq_q));
      clr(0, 8'h0a);
      chk("m_src", 8'h05, src_q[0]);
      clr(0, 8'hff);
      cyc(1);
      chk("cause", 8'h04, 8'(interrupt_cause_reg));
      // Slave arbitration loss, then ACK and NACK; role dropped so later STARTs stay clean
      master_active = 1'h0;
      slave_active = 1'h1;
      i2cis_bus_peer_inst.bit_cell(1'h0);
      chk("s_src", 8'h01, src_q[1]);
      ack_strobe = 1'h1;
      cyc(1);
      ack_strobe = 1'h0;
      i2cis_bus_peer_inst.idle();
      ack_strobe = 1'h1;
      cyc(1);
      ack_strobe = 1'h0;
      slave_active = 1'h0;
      chk("s_src", 8'h07, src_q[1]);
      chk("aborts", 8'h01, 8'(aborts));
      clr(1, 8'hff);
      // Addressed transfer ended by repeated START, then by STOP after a NACKed address
      addr_byte = 8'ha5;
      i2cis_bus_peer_inst.start_cond();
      chk("s_src", 8'h10, src_q[1]);
      am(1'h0);
      chk("s_src", 8'h30, src_q[1]);
      // Not-empty follows the registered count, one edge after the push
      cyc(1);
      chk("rx_src", 8'h04, src_q[3]);
      rx_fw_rd = 1'h1;
      cyc(1);
      rx_fw_rd = 1'h0;
      chk("rx_data", 8'ha5, rx_fw_data_q);
      i2cis_bus_peer_inst.start_cond();
      chk("s_src", 8'h38, src_q[1]);
      addr_accept = 1'h0;
      clr(1, 8'hff);
      am(1'h1);
      i2cis_bus_peer_inst.stop_cond();
      chk("s_src", 8'h28, src_q[1]);
      chk("ec_src", 8'h00, src_q[4]);
      // TX FIFO: fill past full, then drain past empty
      clr(2, 8'hff);
      for (int i = 0; i < 5; i++)
      begin
         tx_fw_data = 8'h10 + 8'(i);
         tx_fw_wr = 1'h1;
         cyc(1);
      end
      tx_fw_wr = 1'h0;
      clr(2, 8'h07);
      chk("tx_src", 8'h08, src_q[2]);
      for (int i = 0; i < 5; i++)
      begin
         tx_hw_rd = 1'h1;
         cyc(1);
         if (i < 4) chk("tx_data", 8'h10 + 8'(i), tx_hw_data_q);
      end
      tx_hw_rd = 1'h0;
      cyc(1);
      chk("tx_src", 8'h1f, src_q[2]);
      // RX FIFO: fill past full, then drain past empty
      clr(3, 8'hff);
      for (int i = 0; i < 5; i++)
      begin
         rx_hw_data = 8'h20 + 8'(i);
         rx_hw_wr = 1'h1;
         cyc(1);
      end
      rx_hw_wr = 1'h0;
      chk("rx_src", 8'h0f, src_q[3]);
      for (int i = 0; i < 5; i++)
      begin
         rx_fw_rd = 1'h1;
         cyc(1);
         if (i < 4) chk("rx_data", 8'h20 + 8'(i), rx_fw_data_q);
      end
      rx_fw_rd = 1'h0;
      chk("rx_src", 8'h1f, src_q[3]);
      // START suppressed only with ext match selected and busy reject off
      ext_clocked_addr_match_sel = 1'h1;
      clr(1, 8'hff);
      i2cis_bus_peer_inst.start_cond();
      i2cis_bus_peer_inst.stop_cond();
      chk("s_src", 8'h00, src_q[1]);
      slave_busy_address_reject = 1'h1;
      byte_active = 1'h1;
      i2cis_bus_peer_inst.start_cond();
      byte_active = 1'h0;
      i2cis_bus_peer_inst.stop_cond();
      chk("s_src", 8'h50, src_q[1]);
      chk("m_src", 8'h10, src_q[0]);
      // Externally clocked sources in buffer and command-response modes
      ext_addr_match_enable = 1'h1;
      ext_operation_enable = 1'h1;
      // Two bytes, base address only, a read, then one byte in command-response mode
      for (int k = 0; k < 4; k++)
      begin
         buffer_memory_mode = (k != 3);
         command_response_mode = (k == 3);
         clr(4, 8'hff);
         i2cis_bus_peer_inst.start_cond();
         am(k == 2);
         for (int j = 0; j < ec_wr[k]; j++)
         begin
            rx_hw_wr = 1'h1;
            cyc(1);
         end
         rx_hw_wr = 1'h0;
         i2cis_bus_peer_inst.stop_cond();
         chk("ec_src", ec_exp[k], src_q[4]);
      end
      report_and_stop();
   end
endmodule // i2c_interrupt_sources_bench
`default_nettype wire

// ### i2cis_bus_peer.sv
// Bus peer model: another I2C party making START, STOP and data bits on the pins
`default_nettype none
module i2cis_bus_peer (
   // Pacing clock
   input  wire logic core_clk,
   // Bus lines, pulled high when released
   output var  logic scl,
   output var  logic sda
);
   timeunit 1ns;
   timeprecision 1ps;

   // Released bus reads high through the pull-ups
   initial
   begin
      scl = 1'h1;
      sda = 1'h1;
   end

   // Each step outlasts the two-flop synchroniser so no edge is missed
   task automatic step(input logic c, input logic d);
      repeat (4) @(negedge core_clk);
      scl = c;
      sda = d;
   endtask

   // START or repeated START: SDA falls while SCL is high
   task automatic start_cond();
      step(1'h0, 1'h1);
      step(1'h1, 1'h1);
      step(1'h1, 1'h0);
      step(1'h0, 1'h0);
   endtask

   // STOP: SDA rises while SCL is high, then the bus is left released
   task automatic stop_cond();
      step(1'h0, 1'h0);
      step(1'h1, 1'h0);
      step(1'h1, 1'h1);
      step(1'h1, 1'h1);
   endtask

   // One bit cell, SDA changed only while SCL is low; leaves SCL low
   task automatic bit_cell(input logic d);
      step(1'h0, d);
      step(1'h1, d);
      step(1'h0, d);
   endtask

   // Return to idle without making a START
   task automatic idle();
      step(1'h0, 1'h1);
      step(1'h1, 1'h1);
   endtask
endmodule // i2cis_bus_peer
`default_nettype wire

// ### i2cis_core.sv
// I2C interrupt sources: event detection, FIFOs, sticky sources and group outputs
//
// What this block does
// - Each group output is the OR of its enabled active sources.
// - A cause output shows which groups currently request service.
// - Clear input with a one clears that source; zero leaves it.
// - Level sources set again at once while their condition persists.
// - Master flags lost arbitration when driven and observed SDA differ with SCL high.
// - Master sets NACK or ACK source from the sampled acknowledge bit.
// - Master sets stop-sent source after finishing a STOP condition.
// - Unexpected START or STOP sets bus error in master and slave groups.
// - Slave flags lost arbitration with SCL high and aborts its transfer.
// - Slave sets NACK or ACK source from the sampled acknowledge bit.
// - Slave stop-received fires on STOP or repeated START ending its transfer.
// - Stop-received fires for any matched address, acked or not.
// - Start-received fires unless ext match selected and busy reject is off.
// - Address match sets its source and pushes address byte when accepted.
// - With ext match and internal operation, match sets source on detection.
// - TX trigger below level; not-full with free entry; empty with none.
// - Firmware write to full TX FIFO flags TX overflow.
// - Hardware read from empty TX FIFO flags TX underflow.
// - RX trigger above level; full; not-empty with an entry present.
// - RX overflow on hardware write when full; underflow on firmware empty read.
// - Wake-up source on matched slave request only with ext match enabled.
// - Stop-after-write on matched write ended by STOP in modes; base-only buffer write excluded.
// - Same conditions give stop-after-read on reads and stop-any on every STOP end.
`include "i2cis_defines.svh"
`default_nettype none
module i2cis_core #(
   parameter int DEPTH = `I2CIS_FIFO_DEPTH,
   parameter int AW    = $clog2(DEPTH)
) (
   // Clock and reset
   input  wire logic               core_clk,
   input  wire logic               rst_n,
   // Bus pins, asynchronous
   input  wire logic               scl_in,
   input  wire logic               sda_in,
   // Bit engine status, same clock
   input  wire logic               sda_drive,
   input  wire logic               master_active,
   input  wire logic               slave_active,
   input  wire logic               ack_strobe,
   input  wire logic               master_stop_done,
   input  wire logic               byte_active,
   input  wire logic               addr_match,
   input  wire logic               addr_rw,
   input  wire logic [7:0]         addr_byte,
   // FIFO ports
   input  wire logic               tx_fw_wr,
   input  wire logic [7:0]         tx_fw_data,
   input  wire logic               tx_hw_rd,
   input  wire logic               rx_hw_wr,
   input  wire logic [7:0]         rx_hw_data,
   input  wire logic               rx_fw_rd,
   input  wire logic [AW:0]        tx_trig_level,
   input  wire logic [AW:0]        rx_trig_level,
   // Configuration
   input  wire logic               ext_addr_match_enable,
   input  wire logic               ext_operation_enable,
   input  wire logic               ext_clocked_addr_match_sel,
   input  wire logic               ext_clocked_operation_sel,
   input  wire logic               slave_busy_address_reject,
   input  wire logic               addr_accept,
   input  wire logic               buffer_memory_mode,
   input  wire logic               command_response_mode,
   // Source clear and mask
   input  wire i2cis_pkg::i2cis_grp_t clr_src,
   input  wire i2cis_pkg::i2cis_grp_t mask_src,
   // Outputs
   output var  i2cis_pkg::i2cis_grp_t src_q,
   output logic [4:0]              irq_q,
   output logic [4:0]              interrupt_cause_reg,
   output logic [7:0]              tx_hw_data_q,
   output logic [7:0]              rx_fw_data_q,
   output logic                    slave_abort_q
);
   import i2cis_pkg::*;

   // Sticky update: set beats a same-cycle clear
   function automatic i2cis_vec_t sticky(i2cis_vec_t q, i2cis_vec_t clr, i2cis_vec_t set);
      sticky = (q & ~clr) | set;
   endfunction

   // Synchronisers and delayed drive value
   logic [2:0] sda_q, sda_d, scl_q, scl_d;
   logic [1:0] drv_q, drv_d;
   always_comb
   begin
      sda_d = {sda_q[1:0], sda_in};
      scl_d = {scl_q[1:0], scl_in};
      drv_d = {drv_q[0], sda_drive};
   end
   always_ff @(posedge core_clk)
   begin
      if (!rst_n)
      begin
         sda_q <= 3'h7;
         scl_q <= 3'h7;
         drv_q <= 2'h3;
      end
      else
      begin
         sda_q <= sda_d;
         scl_q <= scl_d;
         drv_q <= drv_d;
      end
   end

   // Bus condition detection on synchronised lines; bit 0 only feeds the shift into bit 1
   logic sda_s, scl_s, start_det, stop_det, mismatch, bus_err;
   assign sda_s     = sda_q[1];
   assign scl_s     = scl_q[1];
   assign start_det = scl_s & scl_q[2] & sda_q[2] & ~sda_s;
   assign stop_det  = scl_s & scl_q[2] & ~sda_q[2] & sda_s;
   // Drive is delayed to line up with the two-stage synchroniser
   assign mismatch  = scl_s & (drv_q[1] != sda_s);
   assign bus_err   = (start_det | stop_det) & byte_active;

   // TX and RX FIFOs
   logic [7:0]  tx_mem [DEPTH];
   logic [7:0]  rx_mem [DEPTH];
   logic [AW-1:0] tx_wp_q, tx_rp_q, rx_wp_q, rx_rp_q;
   logic [AW-1:0] tx_wp_d, tx_rp_d, rx_wp_d, rx_rp_d;
   logic [AW:0] tx_cnt_q, rx_cnt_q, tx_cnt_d, rx_cnt_d;
   logic [7:0]  tx_dat_d, rx_dat_d, rx_in;
   logic tx_full, tx_empty, rx_full, rx_empty, tx_we, tx_re, rx_we, rx_re;
   logic rx_push, addr_push;
   assign tx_full   = tx_cnt_q == (AW+1)'(DEPTH);
   assign tx_empty  = tx_cnt_q == '0;
   assign rx_full   = rx_cnt_q == (AW+1)'(DEPTH);
   assign rx_empty  = rx_cnt_q == '0;
   assign addr_push = addr_match & addr_accept;
   assign rx_push   = rx_hw_wr | addr_push;
   assign rx_in     = addr_push ? addr_byte : rx_hw_data;
   always_comb
   begin
      tx_we    = tx_fw_wr & ~tx_full;
      tx_re    = tx_hw_rd & ~tx_empty;
      rx_we    = rx_push & ~rx_full;
      rx_re    = rx_fw_rd & ~rx_empty;
      tx_wp_d  = tx_wp_q + AW'(tx_we);
      tx_rp_d  = tx_rp_q + AW'(tx_re);
      rx_wp_d  = rx_wp_q + AW'(rx_we);
      rx_rp_d  = rx_rp_q + AW'(rx_re);
      tx_cnt_d = tx_cnt_q + (AW+1)'(tx_we) - (AW+1)'(tx_re);
      rx_cnt_d = rx_cnt_q + (AW+1)'(rx_we) - (AW+1)'(rx_re);
      tx_dat_d = tx_re ? tx_mem[tx_rp_q] : tx_hw_data_q;
      rx_dat_d = rx_re ? rx_mem[rx_rp_q] : rx_fw_data_q;
   end
   // Memories carry no reset so they can map onto plain RAM
   always_ff @(posedge core_clk)
   begin
      if (tx_we)
         tx_mem[tx_wp_q] <= tx_fw_data;
      if (rx_we)
         rx_mem[rx_wp_q] <= rx_in;
   end
   always_ff @(posedge core_clk)
   begin
      if (!rst_n)
      begin
         tx_wp_q      <= '0;
         tx_rp_q      <= '0;
         rx_wp_q      <= '0;
         rx_rp_q      <= '0;
         tx_cnt_q     <= '0;
         rx_cnt_q     <= '0;
         tx_hw_data_q <= 8'h00;
         rx_fw_data_q <= 8'h00;
      end
      else
      begin
         tx_wp_q      <= tx_wp_d;
         tx_rp_q      <= tx_rp_d;
         rx_wp_q      <= rx_wp_d;
         rx_rp_q      <= rx_rp_d;
         tx_cnt_q     <= tx_cnt_d;
         rx_cnt_q     <= rx_cnt_d;
         tx_hw_data_q <= tx_dat_d;
         rx_fw_data_q <= rx_dat_d;
      end
   end

   // Slave transfer tracker: remembers an addressed transfer until it ends
   i2cis_slv_st_t st_q, st_d;
   logic       rw_q, rw_d;
   logic [1:0] wcnt_q, wcnt_d;
   logic       s_arb, xfer_end, abort_d;
   assign s_arb    = slave_active & mismatch;
   assign xfer_end = (st_q == I2CIS_ST_MATCH) & (stop_det | start_det);
   always_comb
   begin
      st_d    = st_q;
      rw_d    = rw_q;
      wcnt_d  = wcnt_q;
      abort_d = s_arb;
      case (st_q)
         I2CIS_ST_IDLE:
         begin
            if (addr_match && !s_arb)
            begin
               st_d   = I2CIS_ST_MATCH;
               rw_d   = addr_rw;
               wcnt_d = 2'h0;
            end
         end
         I2CIS_ST_MATCH:
         begin
            if (stop_det | start_det | s_arb)
               st_d = I2CIS_ST_IDLE;
            else if (rx_hw_wr && !rw_q && wcnt_q != 2'h2)
               wcnt_d = wcnt_q + 2'h1;
         end
         default:
            st_d = I2CIS_ST_IDLE;
      endcase
   end
   always_ff @(posedge core_clk)
   begin
      if (!rst_n)
      begin
         st_q          <= I2CIS_ST_IDLE;
         rw_q          <= 1'b0;
         wcnt_q        <= 2'h0;
         slave_abort_q <= 1'b0;
      end
      else
      begin
         st_q          <= st_d;
         rw_q          <= rw_d;
         wcnt_q        <= wcnt_d;
         slave_abort_q <= abort_d;
      end
   end

   // Source set terms; level terms re-set while the condition holds
   i2cis_grp_t set, src_d;
   logic [4:0] irq_d;
   logic ec_ok, s_start_ok;
   assign ec_ok = (buffer_memory_mode | command_response_mode) & ext_operation_enable;
   // Stretching with ext match hands START reporting to wake-up and match
   assign s_start_ok = ~(ext_clocked_addr_match_sel & ~slave_busy_address_reject);
   always_comb
   begin
      set = '0;
      set[`I2CIS_GRP_MASTER][`I2CIS_M_ARB]    = master_active & mismatch;
      set[`I2CIS_GRP_MASTER][`I2CIS_M_NACK]   = master_active & ack_strobe & sda_s;
      set[`I2CIS_GRP_MASTER][`I2CIS_M_ACK]    = master_active & ack_strobe & ~sda_s;
      set[`I2CIS_GRP_MASTER][`I2CIS_M_STOP]   = master_stop_done;
      set[`I2CIS_GRP_MASTER][`I2CIS_M_BUSERR] = bus_err;
      set[`I2CIS_GRP_SLAVE][`I2CIS_S_ARB]     = s_arb;
      set[`I2CIS_GRP_SLAVE][`I2CIS_S_NACK]    = slave_active & ack_strobe & sda_s;
      set[`I2CIS_GRP_SLAVE][`I2CIS_S_ACK]     = slave_active & ack_strobe & ~sda_s;
      set[`I2CIS_GRP_SLAVE][`I2CIS_S_STOP]    = xfer_end;
      set[`I2CIS_GRP_SLAVE][`I2CIS_S_START]   = start_det & s_start_ok;
      set[`I2CIS_GRP_SLAVE][`I2CIS_S_ADDR]    = addr_match;
      set[`I2CIS_GRP_SLAVE][`I2CIS_S_BUSERR]  = bus_err;
      set[`I2CIS_GRP_TX][`I2CIS_T_TRIG]       = tx_cnt_q < tx_trig_level;
      set[`I2CIS_GRP_TX][`I2CIS_T_NFULL]      = ~tx_full;
      set[`I2CIS_GRP_TX][`I2CIS_T_EMPTY]      = tx_empty;
      set[`I2CIS_GRP_TX][`I2CIS_T_OVF]        = tx_fw_wr & tx_full;
      set[`I2CIS_GRP_TX][`I2CIS_T_UDF]        = tx_hw_rd & tx_empty;
      set[`I2CIS_GRP_RX][`I2CIS_R_TRIG]       = rx_cnt_q > rx_trig_level;
      set[`I2CIS_GRP_RX][`I2CIS_R_FULL]       = rx_full;
      set[`I2CIS_GRP_RX][`I2CIS_R_NEMPTY]     = ~rx_empty;
      set[`I2CIS_GRP_RX][`I2CIS_R_OVF]        = rx_push & rx_full;
      set[`I2CIS_GRP_RX][`I2CIS_R_UDF]        = rx_fw_rd & rx_empty;
      set[`I2CIS_GRP_EC][`I2CIS_E_WAKE]       = addr_match & ext_addr_match_enable;
      set[`I2CIS_GRP_EC][`I2CIS_E_STOP]       = xfer_end & stop_det & ec_ok;
      // Buffer mode needs a byte past the base address
      set[`I2CIS_GRP_EC][`I2CIS_E_WRSTOP]     = xfer_end & stop_det & ec_ok & ~rw_q
                                                & (command_response_mode | wcnt_q == 2'h2);
      set[`I2CIS_GRP_EC][`I2CIS_E_RDSTOP]     = xfer_end & stop_det & ec_ok & rw_q;
   end

   // Sticky sources and masked group outputs
   for (genvar g = 0; g < 5; g++)
   begin : g_grp
      assign src_d[g] = sticky(src_q[g], clr_src[g], set[g]);
      assign irq_d[g] = |(src_d[g] & mask_src[g]);
   end
   always_ff @(posedge core_clk)
   begin
      if (!rst_n)
      begin
         src_q               <= {5{`I2CIS_SRC_RST}};
         irq_q               <= 5'h00;
         interrupt_cause_reg <= 5'h00;
      end
      else
      begin
         src_q               <= src_d;
         irq_q               <= irq_d;
         interrupt_cause_reg <= irq_d;
      end
   end

   // Checks
   default clocking @(posedge core_clk); endclocking
   default disable iff (!rst_n);
   a_master_ack_set: assert property (master_active && ack_strobe && !sda_s |=> src_q[0][2])
      else $error("master ack not set");
   a_master_nack_set: assert property (master_active && ack_strobe && sda_s |=> src_q[0][1])
      else $error("master nack not set");
   a_stop_sent: assert property (master_stop_done |=> src_q[0][3])
      else $error("stop sent not set");
   a_start_suppress: assert property (ext_clocked_addr_match_sel && !slave_busy_address_reject
      && !src_q[1][4] && !clr_src[1][4] |=> !src_q[1][4] || $past(start_det) == 1'b0)
      else $error("start source not suppressed");
   a_wake_gate: assert property (!src_q[4][0] && !ext_addr_match_enable |=> !src_q[4][0])
      else $error("wake set without ext match");
   a_tx_ovf: assert property (tx_fw_wr && tx_full && !tx_hw_rd
      |=> src_q[2][3] && $stable(tx_cnt_q))
      else $error("tx overflow missed");
   a_rx_udf: assert property (rx_fw_rd && rx_empty |=> src_q[3][4])
      else $error("rx underflow missed");
   a_empty_reset: assert property (tx_empty && clr_src[2][2] |=> src_q[2][2])
      else $error("empty did not re-set");
   a_event_sticky: assert property (src_q[0][3] && !clr_src[0][3] |=> src_q[0][3])
      else $error("event source dropped");
   a_irq_or: assert property (##1 irq_q[2] == |(src_q[2] & $past(mask_src[2])))
      else $error("tx group output wrong");
   a_slave_abort: assert property (s_arb |=> slave_abort_q && st_q == I2CIS_ST_IDLE)
      else $error("slave abort missing");
endmodule // i2cis_core
`default_nettype wire

// ### i2cis_defines.svh
// Constants for the I2C interrupt source block
`ifndef I2CIS_DEFINES_SVH
`define I2CIS_DEFINES_SVH

// Group indices
`define I2CIS_GRP_MASTER 0
`define I2CIS_GRP_SLAVE  1
`define I2CIS_GRP_TX     2
`define I2CIS_GRP_RX     3
`define I2CIS_GRP_EC     4

// Master source bits
`define I2CIS_M_ARB      0
`define I2CIS_M_NACK     1
`define I2CIS_M_ACK      2
`define I2CIS_M_STOP     3
`define I2CIS_M_BUSERR   4

// Slave source bits
`define I2CIS_S_ARB      0
`define I2CIS_S_NACK     1
`define I2CIS_S_ACK      2
`define I2CIS_S_STOP     3
`define I2CIS_S_START    4
`define I2CIS_S_ADDR     5
`define I2CIS_S_BUSERR   6

// TX source bits
`define I2CIS_T_TRIG     0
`define I2CIS_T_NFULL    1
`define I2CIS_T_EMPTY    2
`define I2CIS_T_OVF      3
`define I2CIS_T_UDF      4

// RX source bits
`define I2CIS_R_TRIG     0
`define I2CIS_R_FULL     1
`define I2CIS_R_NEMPTY   2
`define I2CIS_R_OVF      3
`define I2CIS_R_UDF      4

// Externally clocked source bits
`define I2CIS_E_WAKE     0
`define I2CIS_E_STOP     1
`define I2CIS_E_WRSTOP   2
`define I2CIS_E_RDSTOP   3

// Reset values and default FIFO depth
`define I2CIS_SRC_RST    8'h00
`define I2CIS_FIFO_DEPTH 128

`endif

// ### i2cis_pkg.sv
// Types for the I2C interrupt source block
`default_nettype none
package i2cis_pkg;
   typedef logic [7:0] i2cis_vec_t;
   typedef logic [4:0][7:0] i2cis_grp_t;
   typedef enum logic [1:0] {
      I2CIS_ST_IDLE  = 2'b01,
      I2CIS_ST_MATCH = 2'b10
   } i2cis_slv_st_t;
endpackage
`default_nettype wire
